// File: common/aux_pkg.sv
// Constants, channel codes and carrier types for the auxiliary result readout.
// Assumes one 40 MHz device clock and a synchronous active-high reset.
package aux_pkg;

    // ------------------------------------------------------------------
    // Channel sequence
    // ------------------------------------------------------------------
    localparam int AUX_NCH = 21;
    localparam int AUX_NSLOT = 2 * AUX_NCH;

    typedef enum logic [4:0] {
        CH_CELL  = 5'h00, CH_BAT   = 5'h01, CH_REF2  = 5'h02, CH_ZERO  = 5'h03,
        CH_ASUP  = 5'h04, CH_GPIO1 = 5'h05, CH_GPIO2 = 5'h06, CH_GPIO3 = 5'h07,
        CH_GPIO4 = 5'h08, CH_GPIO5 = 5'h09, CH_GPIO6 = 5'h0a, CH_REF3  = 5'h0b,
        CH_OVDAC = 5'h0c, CH_UVDAC = 5'h0d, CH_OTDAC = 5'h0e, CH_UTDAC = 5'h0f,
        CH_WARN  = 5'h10, CH_DSUP  = 5'h11, CH_BIAS  = 5'h12, CH_CSUP  = 5'h13,
        CH_AON   = 5'h14
    } aux_chan_t;

    localparam logic [4:0] AUX_CH_FIRST = 5'h00;
    localparam logic [4:0] AUX_CH_LAST  = 5'h14;
    localparam logic [4:0] AUX_CH_STEP  = 5'h01;

    // ------------------------------------------------------------------
    // Byte selection and diagnostic pattern
    // ------------------------------------------------------------------
    localparam logic [1:0] AUX_BYTE_HI  = 2'h0;
    localparam logic [1:0] AUX_BYTE_MID = 2'h1;
    localparam logic [1:0] AUX_BYTE_LO  = 2'h2;
    localparam logic [7:0] AUX_DIAG_HI  = 8'h80;
    localparam logic [7:0] AUX_DIAG_LO  = 8'h00;
    localparam logic [7:0] AUX_ZERO_B   = 8'h00;

    // ------------------------------------------------------------------
    // Result scaling, for the host's conversion of two's-complement counts
    // ------------------------------------------------------------------
    localparam real AUX_LSB_STD_UV   = 190.7349;
    localparam real AUX_LSB_ASUP_UV  = 381.622;
    localparam real AUX_LSB_CSUP_UV  = 548.47;
    localparam real AUX_LSB_RATIO_PC = 0.00007628;
    localparam real AUX_CELL_GAIN    = 2.0;
    localparam real AUX_WDAC_DIV     = 2.0;
    localparam real AUX_WARN_BASE_C  = 25.0;
    localparam real AUX_WARN_OFS_MV  = 330.0;
    localparam real AUX_WARN_SLOPE   = 1.17;
    localparam real AUX_TRIM_LSB_MV  = 1.0;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SCAN = 4'h2,
        ST_WAIT = 4'h4,
        ST_DONE = 4'h8
    } aux_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       cell_route_en;
        logic [2:0] cell_sel;
        logic [5:0] gpio_en;
        logic [5:0] gpio_ratio;
        logic       stack_voltage_enable;
        logic       warn_sensor_input_enable;
        logic       thermistor_bias_enable;
    } aux_ctrl_t;

    typedef struct packed {
        logic       stb;
        logic       raw;
        logic [4:0] ch;
        logic [1:0] sel;
    } aux_rd_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] corr;
        logic [23:0] raw;
    } aux_conv_t;

endpackage : aux_pkg

// File: verilog/aux_slot.sv
// One result slot: current value, pending value and read lock.
// Assumes rd_hi and rd_lo are one-cycle strobes from the host read decoder.
`timescale 1ns/1ps
module aux_slot
    import aux_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    // Update side
    input  wire logic        clear,
    input  wire logic        wr,
    input  wire logic [23:0] wdata,
    // Host read side
    input  wire logic        rd_hi,
    input  wire logic        rd_lo,
    output logic [23:0]      data,
    output logic             valid
);

    typedef struct packed {
        logic [23:0] cur;
        logic [23:0] pend;
        logic        pend_vld;
        logic        locked;
        logic        valid;
    } aux_slot_st_t;

    aux_slot_st_t s_reg;
    aux_slot_st_t s_next;

    always_comb begin
        s_next = s_reg;
        if (clear) begin
            s_next.valid = 1'b0;
        end
        if (rd_lo && s_reg.locked) begin
            s_next.locked = 1'b0;
            if (s_reg.pend_vld) begin
                s_next.cur      = s_reg.pend;
                s_next.pend_vld = 1'b0;
                s_next.valid    = 1'b1;
            end
        end
        if (rd_hi) begin
            s_next.locked = 1'b1;
        end
        if (wr) begin
            // Value is stored as converted, no window check
            if (s_next.locked) begin
                s_next.pend     = wdata;
                s_next.pend_vld = 1'b1;
            end else begin
                s_next.cur   = wdata;
                s_next.valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign data  = s_reg.cur;
    assign valid = s_reg.valid;

    a_lock_holds_low: assert property (@(posedge clk) disable iff (reset)
        ce && s_reg.locked && wr && !rd_lo |=> $stable(s_reg.cur) && s_reg.pend_vld)
        else $error("locked slot value changed on a new conversion");

    a_pend_applied: assert property (@(posedge clk) disable iff (reset)
        ce && s_reg.locked && s_reg.pend_vld && rd_lo && !rd_hi && !wr
        |=> s_reg.cur == $past(s_reg.pend) && !s_reg.locked)
        else $error("pending value not applied at lock release");

    a_free_write: assert property (@(posedge clk) disable iff (reset)
        ce && wr && !s_reg.locked && !rd_hi |=> s_reg.cur == $past(wdata) && s_reg.valid)
        else $error("unlocked write not stored unchanged");

endmodule : aux_slot

// File: verilog/aux_readout.sv
// Auxiliary converter round sequencer and locked result readout.
// Assumes control bits, start pulse, converter results and host reads all come
// from logic on CLK; the host honours high-byte-first reading.
`timescale 1ns/1ps
module aux_readout
    import aux_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       CE,
    // Configuration and start
    input  wire aux_ctrl_t  CTRL,
    input  wire logic       GO,
    // Converter interface
    output logic            SAMPLE_REQ,
    output logic [4:0]      SAMPLE_CH,
    output logic            SAMPLE_RATIO,
    input  wire aux_conv_t  CONV,
    // Analog routing
    output logic            CELL_ROUTE_EN,
    output logic [2:0]      CELL_ROUTE_SEL,
    output logic            CELL_VOLTAGE_WINDOW_PROTECT_SUSPEND,
    output logic            THERM_BIAS_ON,
    output logic            WARN_INPUT_ON,
    // Status
    output logic            BUSY,
    output logic            DRDY,
    // Host result reads
    input  wire aux_rd_t    RD,
    output logic [7:0]      RD_DATA,
    output logic            RD_VALID
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic is_gpio(input logic [4:0] ch);
        is_gpio = (ch >= CH_GPIO1) && (ch <= CH_GPIO6);
    endfunction : is_gpio

    function automatic logic [2:0] gpio_idx(input logic [4:0] ch);
        logic [4:0] d;
        d = ch - CH_GPIO1;
        gpio_idx = d[2:0];
    endfunction : gpio_idx

    function automatic logic has_raw(input logic [4:0] ch);
        has_raw = is_gpio(ch) || (ch == CH_BAT);
    endfunction : has_raw

    function automatic logic is_wide(input logic raw, input logic [4:0] ch);
        is_wide = raw && ((ch == CH_GPIO1) || (ch == CH_BAT));
    endfunction : is_wide

    function automatic logic chan_enabled(input logic [4:0] ch, input aux_ctrl_t c);
        if (ch == CH_CELL) begin
            chan_enabled = c.cell_route_en;
        end else if (ch == CH_BAT) begin
            chan_enabled = c.stack_voltage_enable;
        end else if (is_gpio(ch)) begin
            chan_enabled = c.gpio_en[gpio_idx(ch)];
        end else if (ch == CH_WARN) begin
            chan_enabled = c.warn_sensor_input_enable;
        end else begin
            chan_enabled = (ch <= AUX_CH_LAST);
        end
    endfunction : chan_enabled

    function automatic logic ratio_of(input logic [4:0] ch, input aux_ctrl_t c);
        ratio_of = is_gpio(ch) ? c.gpio_ratio[gpio_idx(ch)] : 1'b0;
    endfunction : ratio_of

    function automatic logic [7:0] pick_byte(input logic [23:0] d, input logic vld,
                                             input logic wide, input logic [1:0] sel);
        logic [7:0] b;
        b = AUX_ZERO_B;
        if (!vld) begin
            b = (sel == AUX_BYTE_HI) ? AUX_DIAG_HI : AUX_DIAG_LO;
        end else begin
            case (sel)
                AUX_BYTE_HI:  b = wide ? d[23:16] : d[15:8];
                AUX_BYTE_MID: b = wide ? d[15:8] : AUX_ZERO_B;
                AUX_BYTE_LO:  b = d[7:0];
                default:      b = AUX_ZERO_B;
            endcase
        end
        pick_byte = b;
    endfunction : pick_byte

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        aux_state_t  st;
        logic [4:0]  ch;
        logic        busy;
        logic        drdy;
        logic        clear;
        logic        req;
        logic [4:0]  req_ch;
        logic        req_ratio;
        logic        route_en;
        logic [2:0]  route_sel;
        logic        cell_voltage_window_protect_susp;
        logic        bias_on;
        logic        warn_on;
        logic [7:0]  rd_data;
        logic        rd_valid;
    } aux_top_st_t;

    aux_top_st_t s_reg;
    aux_top_st_t s_next;

    logic [23:0] slot_data  [AUX_NSLOT];
    logic        slot_valid [AUX_NSLOT];
    logic        wr_en;
    logic        rd_mapped;
    logic [5:0]  rd_idx;
    logic        cur_ratio;
    logic        cur_en;

    assign wr_en     = (s_reg.st == ST_WAIT) && CONV.valid && !GO;
    assign rd_mapped = (RD.ch <= AUX_CH_LAST) && (!RD.raw || has_raw(RD.ch));
    assign rd_idx    = RD.raw ? 6'(AUX_NCH) + 6'(RD.ch) : 6'(RD.ch);
    assign cur_ratio = ratio_of(s_reg.ch, CTRL);
    assign cur_en    = chan_enabled(s_reg.ch, CTRL);

    // ------------------------------------------------------------------
    // Result slots: corrected bank, then uncorrected bank
    // ------------------------------------------------------------------
    for (genvar g = 0; g < AUX_NSLOT; g++) begin : g_slot
        localparam logic       BANK_RAW = (g >= AUX_NCH);
        localparam logic [4:0] SLOT_CH  = 5'(g % AUX_NCH);
        logic sel_me;
        logic wr_me;
        assign sel_me = RD.stb && rd_mapped && (rd_idx == 6'(g));
        assign wr_me  = wr_en && (s_reg.ch == SLOT_CH) && (!BANK_RAW || has_raw(SLOT_CH));
        aux_slot u_slot (
            .clk   (CLK),
            .reset (RESET),
            .ce    (CE),
            .clear (s_reg.clear),
            .wr    (wr_me),
            .wdata (BANK_RAW ? CONV.raw : {AUX_ZERO_B, CONV.corr}),
            .rd_hi (sel_me && (RD.sel == AUX_BYTE_HI)),
            .rd_lo (sel_me && (RD.sel == AUX_BYTE_LO)),
            .data  (slot_data[g]),
            .valid (slot_valid[g])
        );
    end

    // ------------------------------------------------------------------
    // Sequencer and read path
    // ------------------------------------------------------------------
    always_comb begin
        s_next          = s_reg;
        s_next.req      = 1'b0;
        s_next.clear    = 1'b0;
        s_next.rd_valid = 1'b0;

        // Routing follows the control bits; protection paused while routed
        s_next.route_en  = CTRL.cell_route_en;
        s_next.route_sel = CTRL.cell_sel;
        s_next.cell_voltage_window_protect_susp = CTRL.cell_route_en;
        s_next.bias_on   = CTRL.thermistor_bias_enable;
        s_next.warn_on   = CTRL.warn_sensor_input_enable;

        case (s_reg.st)
            ST_IDLE: begin
                s_next.st = ST_IDLE;
            end
            ST_SCAN: begin
                if (cur_en) begin
                    s_next.req       = 1'b1;
                    s_next.req_ch    = s_reg.ch;
                    s_next.req_ratio = cur_ratio;
                    s_next.st        = ST_WAIT;
                end else if (s_reg.ch == AUX_CH_LAST) begin
                    s_next.st = ST_DONE;
                end else begin
                    s_next.ch = s_reg.ch + AUX_CH_STEP;
                end
            end
            ST_WAIT: begin
                if (CONV.valid) begin
                    if (s_reg.ch == AUX_CH_LAST) begin
                        s_next.st = ST_DONE;
                    end else begin
                        s_next.ch = s_reg.ch + AUX_CH_STEP;
                        s_next.st = ST_SCAN;
                    end
                end
            end
            ST_DONE: begin
                s_next.busy = 1'b0;
                s_next.drdy = 1'b1;
                s_next.st   = ST_IDLE;
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase

        // A start during a round abandons it and restarts the sequence
        if (GO) begin
            s_next.st    = ST_SCAN;
            s_next.ch    = AUX_CH_FIRST;
            s_next.busy  = 1'b1;
            s_next.drdy  = 1'b0;
            s_next.clear = 1'b1;
            s_next.req   = 1'b0;
        end

        if (RD.stb) begin
            s_next.rd_valid = 1'b1;
            if (rd_mapped) begin
                s_next.rd_data = pick_byte(slot_data[rd_idx], slot_valid[rd_idx],
                                           is_wide(RD.raw, RD.ch), RD.sel);
            end else begin
                s_next.rd_data = AUX_ZERO_B;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            s_reg    <= '0;
            s_reg.st <= ST_IDLE;
        end else if (CE) begin
            s_reg <= s_next;
        end
    end

    assign SAMPLE_REQ     = s_reg.req;
    assign SAMPLE_CH      = s_reg.req_ch;
    assign SAMPLE_RATIO   = s_reg.req_ratio;
    assign CELL_ROUTE_EN  = s_reg.route_en;
    assign CELL_ROUTE_SEL = s_reg.route_sel;
    assign CELL_VOLTAGE_WINDOW_PROTECT_SUSPEND   = s_reg.cell_voltage_window_protect_susp;
    assign THERM_BIAS_ON  = s_reg.bias_on;
    assign WARN_INPUT_ON  = s_reg.warn_on;
    assign BUSY           = s_reg.busy;
    assign DRDY           = s_reg.drdy;
    assign RD_DATA        = s_reg.rd_data;
    assign RD_VALID       = s_reg.rd_valid;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_diag_code: assert property (@(posedge CLK) disable iff (RESET)
        CE && RD.stb && rd_mapped && (RD.sel == AUX_BYTE_HI) && !slot_valid[rd_idx]
        |=> RD_DATA == AUX_DIAG_HI && RD_VALID)
        else $error("unfinished result did not read diagnostic code");

    a_go_busy: assert property (@(posedge CLK) disable iff (RESET)
        CE && GO |=> BUSY && !DRDY && s_reg.st == ST_SCAN)
        else $error("start did not raise busy and drop data ready");

    a_done_flags: assert property (@(posedge CLK) disable iff (RESET)
        CE && (s_reg.st == ST_DONE) && !GO |=> !BUSY && DRDY)
        else $error("round end did not swap busy for data ready");

    a_req_enabled: assert property (@(posedge CLK) disable iff (RESET)
        CE && (s_reg.st == ST_SCAN) && !GO && cur_en
        |=> SAMPLE_REQ && SAMPLE_CH == $past(s_reg.ch))
        else $error("enabled channel not requested");

    a_skip_disabled: assert property (@(posedge CLK) disable iff (RESET)
        CE && (s_reg.st == ST_SCAN) && !cur_en |=> !SAMPLE_REQ)
        else $error("disabled channel was requested");

    a_gpio_mode: assert property (@(posedge CLK) disable iff (RESET)
        CE && (s_reg.st == ST_SCAN) && !GO && cur_en && is_gpio(s_reg.ch)
        |=> SAMPLE_RATIO == $past(cur_ratio))
        else $error("gpio mode not passed with request");

    a_cell_voltage_window_protect_suspend: assert property (@(posedge CLK) disable iff (RESET)
        CE |=> CELL_VOLTAGE_WINDOW_PROTECT_SUSPEND == $past(CTRL.cell_route_en) && CELL_ROUTE_EN == CELL_VOLTAGE_WINDOW_PROTECT_SUSPEND)
        else $error("protection not suspended with cell routing");

endmodule : aux_readout

// File: dv/aux_conv_model.sv
// Converter model for the auxiliary readout: answers each sample request.
// Assumes requests, restart and the bench's delay setting change on clk.
`timescale 1ns/1ps
module aux_conv_model
    import aux_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Requests
    input  wire logic       go,
    input  wire logic       req,
    input  wire logic [4:0] ch,
    input  wire logic [7:0] gen,
    input  wire logic [3:0] dly,
    // Result
    output aux_conv_t       conv
);
    logic [3:0] cnt;
    logic       busy;
    logic [4:0] ch_q;

    // -------------------------------------------------------------
    // Answer after dly cycles; a restart drops the pending answer
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        conv.valid <= 1'b0;
        conv.corr  <= ~conv.corr;
        conv.raw   <= ~conv.raw;
        if (reset) begin
            conv <= '0;
            busy <= 1'b0;
        end else if (go) begin
            busy <= 1'b0;
        end else if (req) begin
            busy <= 1'b1;
            cnt  <= dly;
            ch_q <= ch;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                busy <= 1'b0;
                conv <= {1'b1, gen, 3'h0, ch_q, gen, 3'h0, ch_q, ~gen};
            end
        end
    end
endmodule : aux_conv_model

// File: dv/aux_readout_tb_top.sv
// Self-checking bench for the auxiliary result readout.
// Assumes the converter model answers requests; the bench plays the host.
`timescale 1ns/1ps
module aux_readout_tb_top
    import aux_pkg::*;
;
    localparam int        SETTLE = 8;
    localparam aux_ctrl_t ALL_ON = '{1'b1, 3'h5, 6'h3f, 6'h15, 1'b1, 1'b1, 1'b1};
    logic        CLK = 1'b0;
    logic        RESET = 1'b1;
    logic        CE = 1'b1;
    logic        GO = 1'b0;
    aux_ctrl_t   ctrl = '0;
    aux_rd_t     rd = '0;
    aux_conv_t   conv;
    logic        sreq, sratio, route_en, suspend, bias_on, warn_on, busy, drdy, rvalid;
    logic [4:0]  sch;
    logic [2:0]  route_sel;
    logic [7:0]  rdata;
    logic [7:0]  gen = 8'h00;
    logic [3:0]  dly = 4'h1;
    logic [5:0]  q[$];
    logic [23:0] v;
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          seed;
    int          n;

    always #12.5 CLK = ~CLK;

    aux_readout u_aux_readout (
        .CLK(CLK), .RESET(RESET), .CE(CE), .CTRL(ctrl), .GO(GO),
        .SAMPLE_REQ(sreq), .SAMPLE_CH(sch), .SAMPLE_RATIO(sratio), .CONV(conv),
        .CELL_ROUTE_EN(route_en), .CELL_ROUTE_SEL(route_sel), .CELL_VOLTAGE_WINDOW_PROTECT_SUSPEND(suspend),
        .THERM_BIAS_ON(bias_on), .WARN_INPUT_ON(warn_on), .BUSY(busy), .DRDY(drdy),
        .RD(rd), .RD_DATA(rdata), .RD_VALID(rvalid)
    );

    aux_conv_model u_aux_conv_model (
        .clk(CLK), .reset(RESET), .go(GO), .req(sreq), .ch(sch), .gen(gen),
        .dly(dly), .conv(conv)
    );

    // -------------------------------------------------------------
    // Request monitor and hang limit
    // -------------------------------------------------------------
    always @(posedge CLK) begin
        if (sreq === 1'b1) q.push_back({sratio, sch});
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            complete_run();
        end
    end

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic ch_on(input aux_ctrl_t c, input int ch);
        case (ch)
            0: return c.cell_route_en;
            1: return c.stack_voltage_enable;
            16: return c.warn_sensor_input_enable;
            default: return (ch >= 5 && ch <= 10) ? c.gpio_en[ch-5] : 1'b1;
        endcase
    endfunction : ch_on

    task automatic read_slot(input logic raw, input logic [4:0] ch, input logic wide,
                             input int from, input int nb, output logic [23:0] r);
        logic [1:0] sel;
        r = '0;
        for (int i = 0; i < nb; i++) begin
            sel = wide ? 2'(from + i) : (((from + i) == 0) ? AUX_BYTE_HI : AUX_BYTE_LO);
            rd = '{1'b1, raw, ch, sel};
            @(negedge CLK);
            check("read valid", {23'h0, rvalid}, 24'h1);
            r = {r[15:0], rdata};
        end
        rd.stb = 1'b0;
        @(negedge CLK);
    endtask : read_slot

    task automatic check_slot(input logic raw, input int ch, input logic [7:0] g,
                              input logic ok);
        logic [23:0] r;
        logic [23:0] e;
        logic        wide;
        wide = raw && (ch == 1 || ch == 5);
        e = raw ? {wide ? g : 8'h00, 3'h0, 5'(ch), ~g} : {8'h00, g, 3'h0, 5'(ch)};
        if (!ok) e = wide ? 24'h800000 : 24'h008000;
        read_slot(raw, 5'(ch), wide, 0, wide ? 3 : 2, r);
        check($sformatf("slot %0d bank %0b", ch, raw), r, e);
    endtask : check_slot

    task automatic set_ctrl(input aux_ctrl_t c);
        ctrl.cell_route_en = 1'b0;
        @(negedge CLK);
        ctrl = aux_ctrl_t'({1'b0, c[17:0]});
        @(negedge CLK);
        ctrl = c;
        repeat (SETTLE) @(negedge CLK);
        check("routing", {17'h0, route_en, route_sel, suspend, bias_on, warn_on},
              {17'h0, c.cell_route_en, c.cell_sel, c.cell_route_en,
               c.thermistor_bias_enable, c.warn_sensor_input_enable});
    endtask : set_ctrl

    task automatic pulse_go();
        GO = 1'b1;
        @(negedge CLK);
        GO = 1'b0;
        check("busy after start", {22'h0, busy, drdy}, 24'h2);
    endtask : pulse_go

    task automatic wait_done();
        n = 0;
        while (drdy !== 1'b1 && n < 3000) begin
            @(negedge CLK);
            n++;
        end
        check("round done", {22'h0, busy, drdy}, 24'h1);
    endtask : wait_done

    task automatic run_round(input aux_ctrl_t c, input logic [7:0] g, input logic [3:0] d);
        int k;
        set_ctrl(c);
        gen = g;
        dly = d;
        q.delete();
        pulse_go();
        wait_done();
        k = 0;
        for (int ch = 0; ch < AUX_NCH; ch++) begin
            if (ch_on(c, ch)) begin
                check("request", (k < q.size()) ? 24'(q[k]) : 24'hffffff,
                      {18'h0, (ch >= 5 && ch <= 10) ? c.gpio_ratio[ch-5] : 1'b0,
                       5'(ch)});
                k++;
            end
            check_slot(1'b0, ch, g, ch_on(c, ch));
        end
        check("request count", 24'(q.size()), 24'(k));
        for (int ch = 1; ch <= 10; ch++) begin
            if (ch == 1 || ch >= 5) check_slot(1'b1, ch, g, ch_on(c, ch));
        end
        $display("test round %h done", g);
    endtask : run_round

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        seed = 32'hed60d816;
        repeat (4) @(negedge CLK);
        RESET = 1'b0;
        check_slot(1'b0, 3, 8'h00, 1'b0);
        read_slot(1'b0, 5'h15, 1'b0, 0, 2, v);
        check("unmapped channel", v, 24'h0);
        read_slot(1'b1, 5'h02, 1'b0, 0, 2, v);
        check("no raw bank", v, 24'h0);
        CE = 1'b0;
        rd = '{1'b1, 1'b0, 5'h03, AUX_BYTE_HI};
        @(negedge CLK);
        check("frozen read", {23'h0, rvalid}, 24'h0);
        rd.stb = 1'b0;
        CE = 1'b1;
        @(negedge CLK);
        $display("test idle reads done");
        run_round(ALL_ON, 8'h01, 4'h1);
        run_round('{1'b0, 3'h2, 6'h00, 6'h3f, 1'b0, 1'b0, 1'b0}, 8'h02, 4'hf);
        for (int i = 0; i < 6; i++) begin
            run_round(aux_ctrl_t'($random(seed)), 8'(i + 3), 4'(($random(seed) & 7) + 1));
        end
        // Restart mid-round, then lock two slots before their results land
        set_ctrl(ALL_ON);
        gen = 8'h20;
        dly = 4'h6;
        pulse_go();
        repeat (30) @(negedge CLK);
        gen = 8'h21;
        pulse_go();
        read_slot(1'b1, 5'h05, 1'b1, 0, 1, v);
        check("wide locked high", v, 24'h80);
        read_slot(1'b0, 5'h01, 1'b0, 0, 1, v);
        check("stack locked high", v, 24'h80);
        wait_done();
        read_slot(1'b1, 5'h05, 1'b1, 1, 2, v);
        check("wide held bytes", v, 24'h0);
        read_slot(1'b0, 5'h01, 1'b0, 1, 1, v);
        check("stack held low", v, 24'h0);
        check_slot(1'b1, 5, 8'h21, 1'b1);
        check_slot(1'b0, 1, 8'h21, 1'b1);
        check_slot(1'b0, 0, 8'h21, 1'b1);
        check_slot(1'b0, 20, 8'h21, 1'b1);
        $display("test restart and lock done");
        ctrl.warn_sensor_input_enable = 1'b0;
        @(negedge CLK);
        check("warn input off", {23'h0, warn_on}, 24'h0);
        complete_run();
    end
endmodule : aux_readout_tb_top
